//--- rtl/scrb_pkg.sv
package scrb_pkg;
  // ----------------------------------------
  // I/O port addresses
  // ----------------------------------------
  localparam logic [9:0] PORT_SYS_CTRL = 10'h061;
  localparam logic [9:0] PORT_CLK_IDX = 10'h070;
  localparam logic [9:0] PORT_FAST_RST = 10'h092;
  localparam logic [9:0] PORT_CFG_IDX = 10'h1ed;
  localparam logic [9:0] PORT_CFG_DATA = 10'h1ef;
  // ----------------------------------------
  // Configuration indexes
  // ----------------------------------------
  localparam logic [7:0] IDX_ID_HIGH = 8'h00;
  localparam logic [7:0] IDX_ID_LOW = 8'h01;
  localparam logic [7:0] IDX_BANK_CFG = 8'h10;
  localparam logic [7:0] IDX_OPT_CTRL = 8'h11;
  localparam logic [7:0] IDX_SHADOW_LO = 8'h14;
  localparam logic [7:0] IDX_SHADOW_HI = 8'h15;
  localparam logic [7:0] IDX_ROM_MAP = 8'h16;
  localparam logic [7:0] IDX_ROM_CTRL = 8'h17;
  localparam logic [7:0] IDX_CLK_SHADOW = 8'hd0;
  // ----------------------------------------
  // Writable field masks and bit positions
  // ----------------------------------------
  localparam logic [7:0] MASK_BANK_CFG = 8'hdf;
  localparam logic [7:0] MASK_OPT_CTRL = 8'h17;
  localparam logic [7:0] MASK_ROM_CTRL = 8'he3;
  localparam int BIT_FLUSH = 4;
  localparam int BIT_PARITY_DISABLE = 2;
  localparam int BIT_RELOC = 1;
  localparam int BIT_MASTER_SHADOW_ENABLE = 0;
  localparam int BIT_BIOS_WIN = 6;
  localparam int BIT_NMI = 7;
  localparam int BIT_A20 = 1;
  localparam int BIT_FRST = 0;
  localparam logic [4:0] BANK_CODE_MAX = 5'h1c;
  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_CLK_IDX = 8'h80;
  localparam logic [7:0] RST_CFG_IDX = 8'h00;
  localparam int RST_PULSE_NS = 100;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_WIDTH = 5;
endpackage

//--- rtl/scrb_sync.sv
`timescale 1ns/1ns
`default_nettype none
module scrb_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule
`default_nettype wire

//--- rtl/scrb_top.sv
// What this block does
// - Control port bit 7 reads 1 once a DRAM parity error was seen.
// - Control port bit 6 reads 1 while channel check error line is asserted.
// - Control port bit 5 returns live speaker timer output level.
// - Control port bit 4 toggles on every refresh cycle.
// - Control port bit 3, reset 0, suppresses channel check errors when 1.
// - Control port bit 2 disables parity; index 11h parity disable overrides it.
// - Control port bit 1 gates timer output onto speaker pin.
// - Control port bit 0 drives speaker timer gate input.
// - Port 070h bit 7 masks NMI; resets to 1, disabled.
// - Port 070h write presents bits 6:0 on peripheral data bus.
// - Last port 070h value readable at configuration index D0h.
// - Port 092h bit 1 clear forces A20 low, set passes it.
// - Port 092h bit 0 rising edge pulses processor reset high.
// - Index at 1EDh selects register reached through data port 1EFh.
// - Indexes 00h and 01h hold product code and revision, read only.
// - Index 10h bits 4:0 pick bank layout; codes 29 to 31 reserved.
// - Index 10h bits 7:6 memory type; 00 is DRAM.
// - Index 11h bit 4 set drives cache flush output low.
// - Index 11h bit 1 relocates adapter region memory to top.
// - Indexes 14h and 15h enable segment shadowing under master enable.
// - Index 16h bits map segments C0000h to DFFFFh to boot ROM.
// - Index 17h bit 6 picks boot ROM window size.
`timescale 1ns/1ns
`default_nettype none
module scrb_top #(
  parameter logic [11:0] PRODUCT_CODE = 12'h5a3,  // Arbitrary value
  parameter logic [3:0] REVISION_CODE = 4'h2       // Arbitrary value
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Processor I/O cycle, one-cycle strobes on ref_clk
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [9:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rvalid,
  // System pins, asynchronous
  input wire logic parity_error_in,
  input wire logic channel_check_in,
  input wire logic speaker_timer_output,
  input wire logic refresh_pulse,
  input wire logic proc_addr_line_in,
  // Control outputs
  output logic speaker_timer_run,
  output logic speaker_out,
  output logic parity_check_enable,
  output logic channel_check_enable,
  output logic nmi_enable,
  output logic [6:0] peripheral_data_bus,
  output logic peripheral_data_strobe,
  output logic proc_addr_line_out,
  output logic proc_reset_out,
  output logic flush_n,
  output logic relocate_enable,
  output logic [4:0] bank_layout,
  output logic bank_layout_valid,
  output logic [1:0] memory_type,
  output logic [15:0] shadow_enable,
  output logic [7:0] boot_rom_map,
  output logic bios_window_small
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [scrb_pkg::SYNC_WIDTH-1:0] pins_s;

  scrb_sync #(.WIDTH(scrb_pkg::SYNC_WIDTH)) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .async_in({proc_addr_line_in, refresh_pulse, speaker_timer_output, channel_check_in, parity_error_in}),
    .sync_out(pins_s)
  );

  logic parity_s, chk_s, tim_s, ref_s, a20_s;
  assign parity_s = pins_s[0];
  assign chk_s = pins_s[1];
  assign tim_s = pins_s[2];
  assign ref_s = pins_s[3];
  assign a20_s = pins_s[4];

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] ctl_reg, ctl_next;          // bits 3:0 writable
  logic par_flag_reg, par_flag_next;
  logic refresh_toggle_reg, refresh_toggle_next;
  logic ref_prev_reg, ref_prev_next;
  logic [7:0] clk_idx_reg, clk_idx_next;
  logic [1:0] fast_reg, fast_next;
  logic [7:0] config_pointer_reg, config_pointer_next;
  logic [7:0] bank_reg, bank_next;
  logic [7:0] opt_reg, opt_next;
  logic [7:0] shlo_reg, shlo_next;
  logic [7:0] shhi_reg, shhi_next;
  logic [7:0] rom_map_reg, rom_map_next;
  logic [7:0] rom_ctl_reg, rom_ctl_next;
  logic [7:0] rst_cnt_reg, rst_cnt_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic [6:0] pdb_reg, pdb_next;
  logic pdb_stb_reg, pdb_stb_next;

  function automatic logic hit(input logic [9:0] a, input logic [9:0] port);
    hit = (a == port);
  endfunction

  logic wr_cfg;
  assign wr_cfg = io_wr && hit(io_addr, scrb_pkg::PORT_CFG_DATA);

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    ctl_next = ctl_reg;
    clk_idx_next = clk_idx_reg;
    fast_next = fast_reg;
    config_pointer_next = config_pointer_reg;
    bank_next = bank_reg;
    opt_next = opt_reg;
    shlo_next = shlo_reg;
    shhi_next = shhi_reg;
    rom_map_next = rom_map_reg;
    rom_ctl_next = rom_ctl_reg;
    pdb_next = pdb_reg;
    pdb_stb_next = 1'b0;
    ref_prev_next = ref_s;
    // A parity error latches and stays until reset; nothing clears it
    par_flag_next = par_flag_reg | (parity_s & parity_check_enable);
    refresh_toggle_next = refresh_toggle_reg ^ (ref_s & ~ref_prev_reg);
    rst_cnt_next = (rst_cnt_reg != 8'h00) ? rst_cnt_reg - 8'h01 : 8'h00;
    if (io_wr) begin
      if (hit(io_addr, scrb_pkg::PORT_SYS_CTRL)) begin
        ctl_next = {4'h0, io_wdata[3:0]};
      end
      if (hit(io_addr, scrb_pkg::PORT_CLK_IDX)) begin
        clk_idx_next = io_wdata;
        pdb_next = io_wdata[6:0];
        pdb_stb_next = 1'b1;
      end
      if (hit(io_addr, scrb_pkg::PORT_FAST_RST)) begin
        fast_next = io_wdata[1:0];
        if (io_wdata[scrb_pkg::BIT_FRST] && !fast_reg[scrb_pkg::BIT_FRST]) begin
          rst_cnt_next = 8'(scrb_pkg::RST_PULSE_CYC);
        end
      end
      if (hit(io_addr, scrb_pkg::PORT_CFG_IDX)) begin
        config_pointer_next = io_wdata;
      end
    end
    if (wr_cfg) begin
      case (config_pointer_reg)
        scrb_pkg::IDX_BANK_CFG: bank_next = io_wdata & scrb_pkg::MASK_BANK_CFG;
        scrb_pkg::IDX_OPT_CTRL: opt_next = io_wdata & scrb_pkg::MASK_OPT_CTRL;
        scrb_pkg::IDX_SHADOW_LO: shlo_next = io_wdata;
        scrb_pkg::IDX_SHADOW_HI: shhi_next = io_wdata;
        scrb_pkg::IDX_ROM_MAP: rom_map_next = io_wdata;
        scrb_pkg::IDX_ROM_CTRL: rom_ctl_next = io_wdata & scrb_pkg::MASK_ROM_CTRL;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    rvalid_next = io_rd;
    if (io_rd) begin
      case (io_addr)
        scrb_pkg::PORT_SYS_CTRL: rdata_next = {par_flag_reg, chk_s & channel_check_enable, tim_s,
                                               refresh_toggle_reg, ctl_reg[3:0]};
        scrb_pkg::PORT_FAST_RST: rdata_next = {6'h00, fast_reg};
        scrb_pkg::PORT_CFG_IDX: rdata_next = config_pointer_reg;
        scrb_pkg::PORT_CFG_DATA: begin
          case (config_pointer_reg)
            scrb_pkg::IDX_ID_HIGH: rdata_next = PRODUCT_CODE[11:4];
            scrb_pkg::IDX_ID_LOW: rdata_next = {PRODUCT_CODE[3:0], REVISION_CODE};
            scrb_pkg::IDX_BANK_CFG: rdata_next = bank_reg;
            scrb_pkg::IDX_OPT_CTRL: rdata_next = opt_reg;
            scrb_pkg::IDX_SHADOW_LO: rdata_next = shlo_reg;
            scrb_pkg::IDX_SHADOW_HI: rdata_next = shhi_reg;
            scrb_pkg::IDX_ROM_MAP: rdata_next = rom_map_reg;
            scrb_pkg::IDX_ROM_CTRL: rdata_next = rom_ctl_reg;
            scrb_pkg::IDX_CLK_SHADOW: rdata_next = clk_idx_reg;
            default: rdata_next = 8'h00;
          endcase
        end
        // Port 070h is write only; its value is seen through the shadow index
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctl_reg <= scrb_pkg::RST_ZERO;
      par_flag_reg <= 1'b0;
      refresh_toggle_reg <= 1'b0;
      ref_prev_reg <= 1'b0;
      clk_idx_reg <= scrb_pkg::RST_CLK_IDX;
      fast_reg <= 2'h0;
      config_pointer_reg <= scrb_pkg::RST_CFG_IDX;
      bank_reg <= scrb_pkg::RST_ZERO;
      opt_reg <= scrb_pkg::RST_ZERO;
      shlo_reg <= scrb_pkg::RST_ZERO;
      shhi_reg <= scrb_pkg::RST_ZERO;
      rom_map_reg <= scrb_pkg::RST_ZERO;
      rom_ctl_reg <= scrb_pkg::RST_ZERO;
      rst_cnt_reg <= 8'h00;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      pdb_reg <= 7'h00;
      pdb_stb_reg <= 1'b0;
    end else begin
      ctl_reg <= ctl_next;
      par_flag_reg <= par_flag_next;
      refresh_toggle_reg <= refresh_toggle_next;
      ref_prev_reg <= ref_prev_next;
      clk_idx_reg <= clk_idx_next;
      fast_reg <= fast_next;
      config_pointer_reg <= config_pointer_next;
      bank_reg <= bank_next;
      opt_reg <= opt_next;
      shlo_reg <= shlo_next;
      shhi_reg <= shhi_next;
      rom_map_reg <= rom_map_next;
      rom_ctl_reg <= rom_ctl_next;
      rst_cnt_reg <= rst_cnt_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      pdb_reg <= pdb_next;
      pdb_stb_reg <= pdb_stb_next;
    end
  end

  // ----------------------------------------
  // Output flops
  // ----------------------------------------
  // Derived outputs other than speaker_out, proc_addr_line_out and proc_reset_out are computed from next-state values so that they settle
  // on the same edge as the registers behind them; those three lag the registers they are built from by one cycle
  logic spk_reg, spk_next, a20_reg, a20_next, prst_reg, prst_next;
  logic par_en_reg, par_en_next, chk_en_reg, chk_en_next;
  logic nmi_en_reg, nmi_en_next, flush_n_reg, flush_n_next;
  logic blv_reg, blv_next;
  logic [15:0] shadow_reg, shadow_next;

  always_comb begin
    spk_next = tim_s & ctl_reg[1];
    a20_next = a20_s & fast_reg[scrb_pkg::BIT_A20];
    prst_next = (rst_cnt_reg != 8'h00);
    // Index 11h disable wins over the control port enable
    par_en_next = ~ctl_next[2] & ~opt_next[scrb_pkg::BIT_PARITY_DISABLE];
    chk_en_next = ~ctl_next[3];
    nmi_en_next = ~clk_idx_next[scrb_pkg::BIT_NMI];
    flush_n_next = ~opt_next[scrb_pkg::BIT_FLUSH];
    blv_next = (bank_next[4:0] <= scrb_pkg::BANK_CODE_MAX) && (bank_next[7:6] == 2'b00);
    shadow_next = {shhi_next, shlo_next} & {16{opt_next[scrb_pkg::BIT_MASTER_SHADOW_ENABLE]}};
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      spk_reg <= 1'b0;
      a20_reg <= 1'b0;
      prst_reg <= 1'b0;
      par_en_reg <= 1'b1;
      chk_en_reg <= 1'b1;
      nmi_en_reg <= 1'b0;
      flush_n_reg <= 1'b1;
      blv_reg <= 1'b1;
      shadow_reg <= 16'h0000;
    end else begin
      spk_reg <= spk_next;
      a20_reg <= a20_next;
      prst_reg <= prst_next;
      par_en_reg <= par_en_next;
      chk_en_reg <= chk_en_next;
      nmi_en_reg <= nmi_en_next;
      flush_n_reg <= flush_n_next;
      blv_reg <= blv_next;
      shadow_reg <= shadow_next;
    end
  end

  assign io_rdata = rdata_reg;
  assign io_rvalid = rvalid_reg;
  assign speaker_timer_run = ctl_reg[0];
  assign speaker_out = spk_reg;
  assign parity_check_enable = par_en_reg;
  assign channel_check_enable = chk_en_reg;
  assign nmi_enable = nmi_en_reg;
  assign peripheral_data_bus = pdb_reg;
  assign peripheral_data_strobe = pdb_stb_reg;
  assign proc_addr_line_out = a20_reg;
  assign proc_reset_out = prst_reg;
  assign flush_n = flush_n_reg;
  assign relocate_enable = opt_reg[scrb_pkg::BIT_RELOC];
  assign bank_layout = bank_reg[4:0];
  assign bank_layout_valid = blv_reg;
  assign memory_type = bank_reg[7:6];
  assign shadow_enable = shadow_reg;
  assign boot_rom_map = rom_map_reg;
  assign bios_window_small = rom_ctl_reg[scrb_pkg::BIT_BIOS_WIN];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_rising_reset_write;
    io_wr && io_addr == scrb_pkg::PORT_FAST_RST && io_wdata[0] && !fast_reg[0];
  endsequence

  // Ten cycles high in all; the repetition is split to keep its count small
  sequence s_reset_pulse_high;
    proc_reset_out [*8] ##1 proc_reset_out ##1 proc_reset_out;
  endsequence

  a_reset_pulse: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_rising_reset_write |-> ##2 s_reset_pulse_high ##1 !proc_reset_out)
    else $error("processor reset pulse wrong");
  a_nmi_mask: assert property (@(posedge ref_clk) disable iff (!nrst)
    io_wr && io_addr == scrb_pkg::PORT_CLK_IDX |=> nmi_enable == !$past(io_wdata[7]))
    else $error("nmi mask not updated");
  a_pdb_strobe: assert property (@(posedge ref_clk) disable iff (!nrst)
    io_wr && io_addr == scrb_pkg::PORT_CLK_IDX |=> peripheral_data_strobe && peripheral_data_bus == $past(io_wdata[6:0]))
    else $error("peripheral data bus wrong");
  a_parity_sticky: assert property (@(posedge ref_clk) disable iff (!nrst)
    par_flag_reg |=> par_flag_reg)
    else $error("parity flag lost");
  a_refresh_toggle: assert property (@(posedge ref_clk) disable iff (!nrst)
    ref_s && !ref_prev_reg |=> refresh_toggle_reg != $past(refresh_toggle_reg))
    else $error("refresh bit did not toggle");
  a_parity_override: assert property (@(posedge ref_clk) disable iff (!nrst)
    opt_reg[2] |-> !parity_check_enable)
    else $error("parity disable not overriding");
  a_unmapped_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
    io_rd && io_addr == scrb_pkg::PORT_CFG_DATA && config_pointer_reg == 8'h02 |=> io_rvalid && io_rdata == 8'h00)
    else $error("unused index not zero");
  a_shadow_master: assert property (@(posedge ref_clk) disable iff (!nrst)
    !opt_reg[0] |-> shadow_enable == 16'h0000)
    else $error("shadow enabled without master");
  a_id_read: assert property (@(posedge ref_clk) disable iff (!nrst)
    io_rd && io_addr == scrb_pkg::PORT_CFG_DATA && config_pointer_reg == 8'h01
    |=> io_rdata == {PRODUCT_CODE[3:0], REVISION_CODE})
    else $error("identification wrong");
  a_flush_low: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr_cfg && config_pointer_reg == 8'h11 && io_wdata[4] |=> !flush_n)
    else $error("flush not asserted");
endmodule
`default_nettype wire

//--- tb/scrb_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module scrb_host_model (
  // Clock
  input wire logic ref_clk,
  // I/O cycle towards the device
  output logic io_wr,
  output logic io_rd,
  output logic [9:0] io_addr,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid
);
  initial begin
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 10'h3ff;
    io_wdata = 8'h00;
  end

  // Released lines are inverted so a stale address or data never looks valid
  task automatic release_bus();
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = ~io_addr;
    io_wdata = ~io_wdata;
  endtask

  task automatic wr(input logic [9:0] addr, input logic [7:0] data);
    @(negedge ref_clk);
    io_addr = addr;
    io_wdata = data;
    io_wr = 1'b1;
    @(negedge ref_clk);
    release_bus();
  endtask

  task automatic rd(input logic [9:0] addr, output logic [7:0] data, output logic ok);
    int n;
    @(negedge ref_clk);
    io_addr = addr;
    io_rd = 1'b1;
    @(negedge ref_clk);
    release_bus();
    n = 0;
    while (io_rvalid !== 1'b1 && n < 4) begin
      @(negedge ref_clk);
      n++;
    end
    ok = (io_rvalid === 1'b1);
    data = io_rdata;
  endtask
endmodule
`default_nettype wire

//--- tb/tb_system_config_register_bank.sv
`timescale 1ns/1ns
`default_nettype none
module tb_system_config_register_bank;
  localparam logic [11:0] PRODUCT = 12'h3c9;  // Arbitrary value
  localparam logic [3:0] REVISION = 4'h6;  // Arbitrary value
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic io_wr, io_rd, io_rvalid;
  logic [9:0] io_addr;
  logic [7:0] io_wdata, io_rdata, rom_map;
  logic par_in = 1'b0, cc_in = 1'b0, tim = 1'b0, refr = 1'b0, a20 = 1'b0;
  logic spk_run, spk_out, par_en, cc_en, nmi_en, strobe, a20_out, prst, flush_n, reloc, blv, bios_small;
  logic [6:0] pbus;
  logic [4:0] layout;
  logic [1:0] mtype;
  logic [15:0] shadow;
  int n_mismatch = 0;
  int comparisons = 0;
  int seed = 32'h0cc7;
  int mreg [256];
  int idx_tab [8] = '{8'h10, 8'h11, 8'h14, 8'h15, 8'h16, 8'h17, 8'h02, 8'h00};
  int bank_tab [4] = '{8'h1c, 8'h1d, 8'h5c, 8'hff};
  int msys = 0;
  int mfr = 0;
  int mpar = 0;
  int mref = 0;
  int d;

  always #5 ref_clk = ~ref_clk;

  scrb_top #(.PRODUCT_CODE(PRODUCT), .REVISION_CODE(REVISION)) i_scrb_top (
    .ref_clk(ref_clk), .nrst(nrst), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid), .parity_error_in(par_in),
    .channel_check_in(cc_in), .speaker_timer_output(tim), .refresh_pulse(refr),
    .proc_addr_line_in(a20), .speaker_timer_run(spk_run), .speaker_out(spk_out),
    .parity_check_enable(par_en), .channel_check_enable(cc_en), .nmi_enable(nmi_en),
    .peripheral_data_bus(pbus), .peripheral_data_strobe(strobe), .proc_addr_line_out(a20_out),
    .proc_reset_out(prst), .flush_n(flush_n), .relocate_enable(reloc), .bank_layout(layout),
    .bank_layout_valid(blv), .memory_type(mtype), .shadow_enable(shadow), .boot_rom_map(rom_map),
    .bios_window_small(bios_small));

  scrb_host_model i_scrb_host_model (
    .ref_clk(ref_clk), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid));

  // ----------------------------------------
  // Compare and access tasks
  // ----------------------------------------
  task automatic cmp_pin(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t pin got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t read got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic rd_chk(input logic [9:0] a, input int exp);
    logic [7:0] got;
    logic ok;
    i_scrb_host_model.rd(a, got, ok);
    cmp_rd({7'h00, ok}, 8'h01);
    cmp_rd(got, exp[7:0]);
  endtask

  function automatic int sys_exp();
    return {mpar[0], cc_in & ~msys[3], tim, mref[0], msys[3:0]};
  endfunction

  task automatic check_pins();
    cmp_pin(16'(spk_run), 16'(msys[0]));
    cmp_pin(16'(spk_out), 16'(tim & msys[1]));
    cmp_pin(16'(cc_en), 16'(!msys[3]));
    cmp_pin(16'(par_en), 16'(!msys[2] && !mreg[8'h11][2]));
    cmp_pin(16'(nmi_en), 16'(!mreg[8'hd0][7]));
    cmp_pin(16'(a20_out), 16'(mfr[1] & a20));
    cmp_pin(16'(flush_n), 16'(!mreg[8'h11][4]));
    cmp_pin(16'(reloc), 16'(mreg[8'h11][1]));
    cmp_pin(16'(layout), 16'(mreg[8'h10][4:0]));
    cmp_pin(16'(blv), 16'(mreg[8'h10][4:0] <= scrb_pkg::BANK_CODE_MAX && mreg[8'h10][7:6] == 2'h0));
    cmp_pin(16'(mtype), 16'(mreg[8'h10][7:6]));
    cmp_pin(shadow, {mreg[8'h15][7:0], mreg[8'h14][7:0]} & {16{mreg[8'h11][0]}});
    cmp_pin(16'(rom_map), 16'(mreg[8'h16][7:0]));
    cmp_pin(16'(bios_small), 16'(mreg[8'h17][6]));
  endtask

  task automatic cfg_wr(input int idx, input int dat);
    int m;
    m = (idx == 8'h10) ? scrb_pkg::MASK_BANK_CFG : (idx == 8'h11) ? scrb_pkg::MASK_OPT_CTRL :
        (idx == 8'h17) ? scrb_pkg::MASK_ROM_CTRL : (idx >= 8'h14 && idx <= 8'h16) ? 8'hff : 8'h00;
    i_scrb_host_model.wr(scrb_pkg::PORT_CFG_IDX, idx[7:0]);
    i_scrb_host_model.wr(scrb_pkg::PORT_CFG_DATA, dat[7:0]);
    mreg[idx] = dat & m;
    check_pins();
  endtask

  task automatic cfg_rd(input int idx);
    i_scrb_host_model.wr(scrb_pkg::PORT_CFG_IDX, idx[7:0]);
    rd_chk(scrb_pkg::PORT_CFG_IDX, idx);
    rd_chk(scrb_pkg::PORT_CFG_DATA, (idx == 0) ? PRODUCT[11:4] : (idx == 1) ? {PRODUCT[3:0], REVISION} : mreg[idx]);
  endtask

  // Counts reset pulse cycles well past the expected pulse length
  task automatic fr_wr(input int dat, input int exp);
    int cnt;
    i_scrb_host_model.wr(scrb_pkg::PORT_FAST_RST, dat[7:0]);
    mfr = dat & 3;
    cnt = 0;
    repeat (16) begin
      @(negedge ref_clk);
      cnt += (prst === 1'b1);
    end
    cmp_pin(16'(cnt), 16'(exp));
    check_pins();
    rd_chk(scrb_pkg::PORT_FAST_RST, mfr);
  endtask

  task automatic print_verdict();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 256; i++) begin
      mreg[i] = 0;
    end
    mreg[8'hd0] = scrb_pkg::RST_CLK_IDX;
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    nrst = 1'b1;
    wait_cyc(3);
    check_pins();
    rd_chk(scrb_pkg::PORT_SYS_CTRL, sys_exp());
    cfg_rd(8'h00);
    cfg_wr(8'h01, 8'hff);
    cfg_rd(8'h01);
    for (int i = 0; i < 4; i++) begin
      cfg_wr(8'h10, bank_tab[i]);
      cfg_rd(8'h10);
    end
    for (int i = 0; i < 40; i++) begin
      cfg_wr(idx_tab[i % 8], $random(seed) & 8'hff);
      cfg_rd(idx_tab[i % 8]);
    end
    for (int i = 0; i < 12; i++) begin
      d = $random(seed);
      tim = d[4];
      cc_in = d[5];
      for (int k = 0; k < d[7:6]; k++) begin
        refr = 1'b1;
        wait_cyc(3);
        refr = 1'b0;
        wait_cyc(3);
        mref++;
      end
      i_scrb_host_model.wr(scrb_pkg::PORT_SYS_CTRL, d[7:0]);
      msys = d & 15;
      wait_cyc(4);
      check_pins();
      rd_chk(scrb_pkg::PORT_SYS_CTRL, sys_exp());
    end
    for (int i = 0; i < 8; i++) begin
      d = ($random(seed) & 8'h7f) | ((i & 1) << 7);
      i_scrb_host_model.wr(scrb_pkg::PORT_CLK_IDX, d[7:0]);
      cmp_pin(16'(strobe), 16'h0001);
      cmp_pin(16'(pbus), 16'(d[6:0]));
      mreg[8'hd0] = d;
      check_pins();
      cfg_rd(8'hd0);
      rd_chk(scrb_pkg::PORT_CLK_IDX, 0);
    end
    a20 = 1'b1;
    fr_wr(8'h00, 0);
    fr_wr(8'h02, 0);
    fr_wr(8'h03, scrb_pkg::RST_PULSE_CYC);
    fr_wr(8'h03, 0);
    a20 = 1'b0;
    fr_wr(8'h02, 0);
    // Parity disabled by the port bit, then by the override, then enabled
    for (int i = 0; i < 3; i++) begin
      i_scrb_host_model.wr(scrb_pkg::PORT_SYS_CTRL, (i == 0) ? 8'h04 : 8'h00);
      msys = (i == 0) ? 4 : 0;
      cfg_wr(8'h11, (i == 1) ? 8'h04 : 8'h00);
      par_in = 1'b1;
      wait_cyc(4);
      par_in = 1'b0;
      wait_cyc(4);
      mpar = (i == 2) ? 1 : 0;
      rd_chk(scrb_pkg::PORT_SYS_CTRL, sys_exp());
    end
    rd_chk(10'h2a5, 0);
    print_verdict();
  end

  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
endmodule
`default_nettype wire
